// file: common/sub_exec_pkg.sv
// Constants for the byte subtract execution datapath.
// Assumes a core that presents one 16-bit instruction word per instruction cycle.
package sub_exec_pkg;
    // Instruction encodings
    localparam logic [7:0]  OPC_IMM_HI      = 8'h08;    // Upper byte of literal subtract
    localparam logic [5:0]  OPC_REG_HI      = 6'h17;    // Upper six bits of register subtract
    localparam int          DEST_BIT        = 9;
    localparam int          BANK_BIT        = 8;
    // Indexed literal offset limit
    localparam logic [7:0]  IDX_LIMIT       = 8'h5F;
    // Access window split: low part is bank 0, rest maps to the top bank
    localparam logic [7:0]  ACC_SPLIT       = 8'h60;
    localparam logic [3:0]  ACC_HIGH_BANK   = 4'hF;
    // Reset values
    localparam logic [7:0]  ACC_RST         = 8'h00;
    localparam logic [4:0]  FLAGS_RST       = 5'h00;
    // Flag positions in the status byte
    localparam int          FL_CARRY        = 0;
    localparam int          FL_HALF         = 1;
    localparam int          FL_ZERO         = 2;
    localparam int          FL_WRAP         = 3;
    localparam int          FL_SIGN         = 4;
    // Quarter phases, one-hot
    typedef enum logic [3:0] {
        PH_DECODE  = 4'h1,
        PH_READ    = 4'h2,
        PH_PROCESS = 4'h4,
        PH_WRITE   = 4'h8
    } phase_e;
endpackage

// file: src/byte_sub_alu.sv
// Combinational 8-bit subtractor: minuend minus subtrahend with flags.
// Assumes the caller registers results; carry means no borrow.
`timescale 1ns/1ps
module byte_sub_alu #(
    parameter int WIDTH = 8
) (
    // Operands
    input  wire logic [WIDTH-1:0] minuend,
    input  wire logic [WIDTH-1:0] subtrahend,
    // Results
    output logic      [WIDTH-1:0] diff,
    output logic      [4:0]       flags
);
    // Elaboration check: the nibble and sign flag logic assumes a byte datapath
    if (WIDTH != 8) begin
        $error("byte_sub_alu supports WIDTH 8 only");
    end

    logic [WIDTH:0] full;
    logic [4:0]     low;

    // Two's complement subtraction; flags follow carry-is-inverted-borrow
    always_comb begin
        full  = {1'b0, minuend} - {1'b0, subtrahend};
        low   = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
        diff  = full[WIDTH-1:0];
        flags = '0;
        flags[sub_exec_pkg::FL_CARRY] = ~full[WIDTH];
        flags[sub_exec_pkg::FL_HALF]  = ~low[4];
        flags[sub_exec_pkg::FL_ZERO]  = (full[WIDTH-1:0] == '0);
        flags[sub_exec_pkg::FL_SIGN]  = full[WIDTH-1];
        flags[sub_exec_pkg::FL_WRAP]  = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1])
                                        & (full[WIDTH-1] ^ minuend[WIDTH-1]);
    end
endmodule

// file: src/byte_subtract_exec.sv
// Execution datapath for the literal subtract and register subtract instructions.
// Assumes a core instruction word held stable while start is pulsed, and a
// data memory with combinational read data and a one-cycle write strobe.
// Contract
// - Literal subtract: immediate minus accumulator into accumulator, opcode byte 08.
// - Literal subtract uses one cycle: decode, read, process, write quarters.
// - Register subtract: register value minus accumulator, two's complement.
// - Destination bit zero writes accumulator, register left unchanged.
// - Destination bit one writes difference back into the register.
// - Bank bit zero uses access window; one uses bank select register.
// - Extended set and bank zero: addresses to 5F are indexed offsets.
// - Register subtract uses one cycle: decode, read, process, write quarters.
// - Positive nonzero difference sets carry, clears zero and sign.
// - Zero difference sets carry and zero, clears sign.
// - Negative difference clears carry, sets sign, clears zero.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module byte_subtract_exec (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Instruction issue
    input  wire logic        start,
    input  wire logic [15:0] instr,
    input  wire logic        ext_set_en,
    input  wire logic [3:0]  bank_select_reg,
    input  wire logic [11:0] index_base,
    // Data memory
    output logic      [11:0] mem_addr,
    input  wire logic [7:0]  mem_rdata,
    output logic             mem_we,
    output logic      [7:0]  mem_wdata,
    // Architectural state
    output logic      [7:0]  acc,
    output logic             carry_flag,
    output logic             half_borrow_flag,
    output logic             zero_flag,
    output logic             signed_wrap_flag,
    output logic             sign_flag,
    // Status
    output logic             busy,
    output logic             done,
    output logic             illegal
);
    typedef struct packed {
        // Sequencer control
        sub_exec_pkg::phase_e phase;
        logic                 active;
        // Captured decode of the word in flight
        logic                 is_reg;
        logic                 dest_reg;
        logic [11:0]          addr;
        // Datapath holding registers between quarters
        logic [7:0]           opnd;
        logic [7:0]           diff;
        logic [4:0]           flags;
        // Architectural state seen by software
        logic [7:0]           acc;
        logic [4:0]           status;
        // One-cycle strobes and the write data beside them
        logic                 we;
        logic [7:0]           wdata;
        logic                 done;
        logic                 illegal;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // Subtractor results, used only in the process quarter
    logic [7:0]  alu_diff;
    logic [4:0]  alu_flags;
    // Fields of the word on the issue port
    logic        is_imm;
    logic        is_reg;
    logic        dest_bit;
    logic        bank_bit;
    logic [7:0]  fld;
    // Candidate operand addresses, one for each addressing form
    logic [11:0] bank_addr;
    logic [11:0] idx_addr;
    logic [11:0] win_addr;
    logic        idx_hit;
    logic        win_low;
    logic [11:0] eff_addr;

    // Elaboration checks on the shared constants: a bad package edit would
    // otherwise mis-decode words quietly instead of failing at build time
    if (sub_exec_pkg::DEST_BIT == sub_exec_pkg::BANK_BIT) begin
        $error("destination and bank bits must differ");
    end
    // Both mode bits sit between the register field and the opcode
    if ((sub_exec_pkg::DEST_BIT < $bits(fld))
        || (sub_exec_pkg::DEST_BIT >= $bits(instr) - $bits(sub_exec_pkg::OPC_REG_HI))) begin
        $error("destination bit overlaps another field");
    end
    if ((sub_exec_pkg::BANK_BIT < $bits(fld))
        || (sub_exec_pkg::BANK_BIT >= $bits(instr) - $bits(sub_exec_pkg::OPC_REG_HI))) begin
        $error("bank bit overlaps another field");
    end
    // Indexed offsets must be a subset of the low part of the window
    if (sub_exec_pkg::IDX_LIMIT >= sub_exec_pkg::ACC_SPLIT) begin
        $error("indexed offset limit must lie below the window split");
    end
    // A bank number and a register field must fill a data address exactly
    if ($bits(bank_select_reg) + $bits(fld) != $bits(eff_addr)) begin
        $error("bank and register field do not fill an address");
    end
    if ($bits(sub_exec_pkg::ACC_HIGH_BANK) != $bits(bank_select_reg)) begin
        $error("top bank number has the wrong width");
    end
    if ($bits(index_base) != $bits(eff_addr)) begin
        $error("index base has the wrong width");
    end
    // Every flag position must fall inside the status vector
    if ((sub_exec_pkg::FL_CARRY >= $bits(alu_flags)) || (sub_exec_pkg::FL_HALF >= $bits(alu_flags))
        || (sub_exec_pkg::FL_ZERO >= $bits(alu_flags)) || (sub_exec_pkg::FL_WRAP >= $bits(alu_flags))
        || (sub_exec_pkg::FL_SIGN >= $bits(alu_flags))) begin
        $error("flag position outside the status vector");
    end
    // Reset constants must match the registers they load
    if (($bits(sub_exec_pkg::ACC_RST) != $bits(acc)) || ($bits(sub_exec_pkg::FLAGS_RST) != $bits(alu_flags))) begin
        $error("reset constant has the wrong width");
    end
    // Each quarter owns exactly one flip-flop of the phase code
    if (($countones(sub_exec_pkg::PH_DECODE) != 1) || ($countones(sub_exec_pkg::PH_READ) != 1)
        || ($countones(sub_exec_pkg::PH_PROCESS) != 1) || ($countones(sub_exec_pkg::PH_WRITE) != 1)) begin
        $error("phase codes must be one-hot");
    end

    // Opcode recognition; evaluated every cycle but used only beside start
    // opcode byte match
    assign is_imm   = (instr[15:8] == sub_exec_pkg::OPC_IMM_HI);
    assign is_reg   = (instr[15:10] == sub_exec_pkg::OPC_REG_HI);
    assign fld      = instr[7:0];
    // Mode bits are zero bits of opcode byte 08 in the literal form; the destination bit is also masked at decode
    assign dest_bit = instr[sub_exec_pkg::DEST_BIT];
    assign bank_bit = instr[sub_exec_pkg::BANK_BIT];

    // Candidate addresses, all formed in parallel so the final mux stays shallow
    // banked address
    assign bank_addr = {bank_select_reg, fld};
    // indexed literal offset; the sum wraps at the top of data space
    assign idx_addr  = index_base + {4'h0, fld};
    assign idx_hit   = ext_set_en && (fld <= sub_exec_pkg::IDX_LIMIT);
    // Access window: low part in bank zero, upper part in the top bank
    assign win_low   = (fld < sub_exec_pkg::ACC_SPLIT);
    assign win_addr  = win_low ? {4'h0, fld} : {sub_exec_pkg::ACC_HIGH_BANK, fld};

    // Effective address of the register operand
    always_comb begin
        if (bank_bit) begin
            eff_addr = bank_addr;
        // indexed mode takes precedence over the window
        end else if (idx_hit) begin
            eff_addr = idx_addr;
        end else begin
            eff_addr = win_addr;
        end
    end

    // Shared subtractor: operand minus accumulator
    byte_sub_alu #(
        .WIDTH (8)
    ) u_alu (
        .minuend    (st_r.opnd),
        .subtrahend (st_r.acc),
        .diff       (alu_diff),
        .flags      (alu_flags)
    );

    // Quarter phase sequencer; one instruction takes four ref_clk edges
    // Strobes fall back to zero by default, so each lasts exactly one cycle
    always_comb begin
        st_nxt         = st_r;
        st_nxt.we      = 1'b0;
        st_nxt.done    = 1'b0;
        st_nxt.illegal = 1'b0;
        case (st_r.phase)
            sub_exec_pkg::PH_DECODE: begin
                // decode quarter
                // The word is looked at only here; later quarters use the
                // captured copy, so the core may change instr right away
                if (start) begin
                    if (is_imm || is_reg) begin
                        st_nxt.active   = 1'b1;
                        st_nxt.is_reg   = is_reg;
                        // Literal form has no destination field: accumulator only
                        st_nxt.dest_reg = is_reg & dest_bit;
                        // Address fixed now; bank and index inputs may move later
                        st_nxt.addr     = eff_addr;
                        st_nxt.opnd     = fld;
                        st_nxt.phase    = sub_exec_pkg::PH_READ;
                    end else begin
                        st_nxt.illegal  = 1'b1;  // Not ours; ignored
                    end
                end
            end
            sub_exec_pkg::PH_READ: begin
                // read register operand
                // mem_addr has stood a full cycle, so the read data is settled
                if (st_r.is_reg) begin
                    st_nxt.opnd = mem_rdata;
                end
                st_nxt.phase = sub_exec_pkg::PH_PROCESS;
            end
            sub_exec_pkg::PH_PROCESS: begin
                // overflow and half borrow
                // Result and flags stay private until the write quarter
                st_nxt.diff  = alu_diff;
                st_nxt.flags = alu_flags;
                st_nxt.phase = sub_exec_pkg::PH_WRITE;
            end
            sub_exec_pkg::PH_WRITE: begin
                // negative result flags committed
                // All five flags change together, on the same edge as done
                st_nxt.status = st_r.flags;
                if (st_r.dest_reg) begin
                    st_nxt.we    = 1'b1;
                    st_nxt.wdata = st_r.diff;
                end else begin
                    st_nxt.acc   = st_r.diff;
                end
                // Back to decode at once, so a new start may stand beside done
                st_nxt.active = 1'b0;
                st_nxt.done   = 1'b1;
                st_nxt.phase  = sub_exec_pkg::PH_DECODE;
            end
            default: begin
                // Unreachable code; recover to idle rather than lock up
                st_nxt.phase  = sub_exec_pkg::PH_DECODE;
                st_nxt.active = 1'b0;
            end
        endcase
    end

    // State register
    // Reset leaves the sequencer idle in decode with a clear accumulator
    // and clear flags, so the first start may follow at the next edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r          <= '0;
            st_r.phase    <= sub_exec_pkg::PH_DECODE;
            st_r.acc      <= sub_exec_pkg::ACC_RST;
            st_r.status   <= sub_exec_pkg::FLAGS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state flip-flops, so none can glitch;
    // the address is held in state for the whole instruction
    // Data memory side
    assign mem_addr         = st_r.addr;
    assign mem_we           = st_r.we;
    assign mem_wdata        = st_r.wdata;
    // Accumulator and flags, visible from the edge that raises done
    assign acc              = st_r.acc;
    assign carry_flag       = st_r.status[sub_exec_pkg::FL_CARRY];
    assign half_borrow_flag = st_r.status[sub_exec_pkg::FL_HALF];
    assign zero_flag        = st_r.status[sub_exec_pkg::FL_ZERO];
    assign signed_wrap_flag = st_r.status[sub_exec_pkg::FL_WRAP];
    assign sign_flag        = st_r.status[sub_exec_pkg::FL_SIGN];
    // Sequencer status; done and illegal are single-cycle strobes
    assign busy             = st_r.active;
    assign done             = st_r.done;
    assign illegal          = st_r.illegal;
endmodule

// file: sim/sub_exec_properties.sv
// Checker on the subtract datapath ports.
// Assumes mode inputs stay still during an instruction.
`timescale 1ns/1ps
module sub_exec_properties (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    // Issue
    input wire logic        start,
    input wire logic        ext_set_en,
    input wire logic [15:0] instr,
    input wire logic [3:0]  bank_select_reg,
    input wire logic [11:0] index_base,
    // Memory
    input wire logic [11:0] mem_addr,
    input wire logic [7:0]  mem_rdata,
    input wire logic [7:0]  mem_wdata,
    input wire logic        mem_we,
    // State
    input wire logic [7:0]  acc,
    input wire logic        carry_flag,
    input wire logic        half_borrow_flag,
    input wire logic        zero_flag,
    input wire logic        signed_wrap_flag,
    input wire logic        sign_flag,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        illegal
);
    logic [15:0] ins_r;
    logic        take, legal, rop;
    logic [7:0]  res;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Word in flight; start while busy is ignored
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) ins_r <= 16'h0000;
        else if (take) ins_r <= instr;
    end
    assign take = start && !busy;
    assign legal = instr[15:8] == sub_exec_pkg::OPC_IMM_HI || instr[15:10] == sub_exec_pkg::OPC_REG_HI;
    assign rop = ins_r[15:10] == sub_exec_pkg::OPC_REG_HI;
    assign res = mem_we ? mem_wdata : acc; // Where the difference went
    done_latency_a: assert property (take && legal |-> ##4 done) else $error("late done");
    busy_span_a: assert property (take && legal |=> busy [*3] ##1 !busy) else $error("busy span");
    illegal_pulse_a: assert property (take && !legal |=> illegal) else $error("no illegal");
    imm_nowrite_a: assert property (done && !rop |-> !mem_we) else $error("literal wrote");
    dest_select_a: assert property (done && rop |-> mem_we == ins_r[sub_exec_pkg::DEST_BIT]) else $error("dest");
    acc_kept_a: assert property (done && mem_we |-> $stable(acc)) else $error("acc moved");
    zero_flag_a: assert property (done |-> zero_flag == (res == 8'h00)) else $error("zero flag");
    sign_flag_a: assert property (done |-> sign_flag == res[7]) else $error("sign flag");
    bank_addr_a: assert property (busy && rop && ins_r[sub_exec_pkg::BANK_BIT]
        |-> mem_addr == {bank_select_reg, ins_r[7:0]}) else $error("bank addr");
    index_addr_a: assert property (busy && rop && !ins_r[sub_exec_pkg::BANK_BIT] && ext_set_en
        && ins_r[7:0] <= sub_exec_pkg::IDX_LIMIT |-> mem_addr == index_base + {4'h0, ins_r[7:0]}) else $error("idx");
    cover property (done && mem_we);
    cover property (illegal);
    cover property (done && !carry_flag);
endmodule
bind byte_subtract_exec sub_exec_properties u_props (
    .ref_clk          (ref_clk),
    .resetn           (resetn),
    .start            (start),
    .ext_set_en       (ext_set_en),
    .instr            (instr),
    .bank_select_reg  (bank_select_reg),
    .index_base       (index_base),
    .mem_addr         (mem_addr),
    .mem_rdata        (mem_rdata),
    .mem_wdata        (mem_wdata),
    .mem_we           (mem_we),
    .acc              (acc),
    .carry_flag       (carry_flag),
    .half_borrow_flag (half_borrow_flag),
    .zero_flag        (zero_flag),
    .signed_wrap_flag (signed_wrap_flag),
    .sign_flag        (sign_flag),
    .busy             (busy),
    .done             (done),
    .illegal          (illegal)
);

// file: sim/data_mem_model.sv
// Data memory model: combinational read, write on strobe.
// Assumes the bench seeds cells by hierarchy.
`timescale 1ns/1ps
module data_mem_model (
    // Clock and write strobe
    input  wire logic        ref_clk,
    input  wire logic        mem_we,
    // Address and data
    input  wire logic [11:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [4096];
    // Read follows the address with no delay
    assign mem_rdata = mem[mem_addr];
    // Plain always, since the bench also seeds cells from its own process
    always @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule

// file: sim/byte_subtract_exec_tb.sv
// Bench: issues subtract words, checks results, flags and memory.
// Assumes the memory model answers the datapath.
`timescale 1ns/1ps
module byte_subtract_exec_tb;
    logic        ref_clk, resetn, start, ext_set_en, mem_we, busy, done, illegal;
    logic        carry_flag, half_borrow_flag, zero_flag, signed_wrap_flag, sign_flag;
    logic [15:0] instr;
    logic [3:0]  bank_select_reg;
    logic [11:0] index_base, mem_addr;
    logic [7:0]  mem_rdata, mem_wdata, acc, acc_m;
    int          err_total, comparisons;
    byte_subtract_exec uut (.ref_clk(ref_clk), .resetn(resetn), .start(start), .instr(instr),
        .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg), .index_base(index_base),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc),
        .carry_flag(carry_flag), .half_borrow_flag(half_borrow_flag), .zero_flag(zero_flag),
        .signed_wrap_flag(signed_wrap_flag), .sign_flag(sign_flag), .busy(busy), .done(done), .illegal(illegal));
    data_mem_model u_mem (.ref_clk(ref_clk), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Flags packed as the package orders them; carry means no borrow
    function automatic logic [7:0] flg(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {3'h0, d[7], (a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b};
    endfunction
    // One instruction; the wait is bounded so a hang ends the run
    task automatic sub(input logic [15:0] w, input logic [11:0] a, input logic [7:0] v);
        logic [7:0] m, r;
        logic       wr;
        int         i;
        wr = w[15:10] == sub_exec_pkg::OPC_REG_HI && w[sub_exec_pkg::DEST_BIT];
        u_mem.mem[a] = v;
        m = (w[15:10] == sub_exec_pkg::OPC_REG_HI) ? v : w[7:0];
        r = m - acc_m;
        @(posedge ref_clk) start <= 1'b1;
        instr <= w;
        @(posedge ref_clk) start <= 1'b0;
        for (i = 0; i < 8 && done !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (done !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t no done", $time);
            tally_and_finish;
        end else begin
            chk({3'h0, sign_flag, signed_wrap_flag, zero_flag, half_borrow_flag, carry_flag}, flg(m, acc_m), "flags");
            if (!wr) acc_m = r;
            chk(acc, acc_m, "acc");
            @(posedge ref_clk);
            #1;
            chk(u_mem.mem[a], wr ? r : v, "mem");
        end
    endtask
    initial begin
        {resetn, start, ext_set_en, instr, acc_m} = '0;
        {bank_select_reg, index_base} = {4'h5, 12'h300};
        {err_total, comparisons} = '0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        chk(acc, 8'h00, "reset acc");
        sub(16'h0802, 12'h010, 8'h11);
        sub(16'h0802, 12'h010, 8'h11);
        sub(16'h0802, 12'h010, 8'h11);
        sub(16'h0801, 12'h010, 8'h11);
        sub(16'h087F, 12'h010, 8'h11);
        $display("test literal done");
        sub(16'h5E20, 12'h020, 8'h03);
        sub(16'h5CA0, 12'hFA0, 8'h80);
        sub(16'h5F33, 12'h533, 8'h44);
        @(posedge ref_clk) ext_set_en <= 1'b1;
        sub(16'h5C5F, 12'h35F, 8'h10);
        sub(16'h5C60, 12'hF60, 8'h09);
        $display("test register done");
        @(posedge ref_clk) start <= 1'b1;
        instr <= 16'hFFFF;
        @(posedge ref_clk) start <= 1'b0;
        #1;
        chk({7'h00, illegal}, 8'h01, "illegal");
        repeat (5) @(posedge ref_clk);
        chk(acc, acc_m, "acc kept");
        $display("test illegal done");
        tally_and_finish;
    end
endmodule
